// ===== rtl/mlic_pkg.sv
// Package of the multilevel interrupt controller: vector bases, levels,
// widths and timing counts.
// Assumes a 20 MHz system clock and word-addressed program memory.
package mlic_pkg;

  localparam int NUM_SRC  = 16;
  localparam int SRC_W    = 4;
  localparam int VEC_W    = 16;
  localparam int OFS_W    = 4;

  // Levels
  localparam logic [1:0] LVL_OFF  = 2'h0;
  localparam logic [1:0] LVL_LOW  = 2'h1;
  localparam logic [1:0] LVL_MED  = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;

  // Word addresses of the vector table
  localparam logic [VEC_W-1:0] RESET_VECTOR            = 16'h0000;
  localparam logic [VEC_W-1:0] OSCILLATOR_FAIL_VECTOR  = 16'h0002;
  localparam logic [VEC_W-1:0] PORT_C_IRQ_BASE         = 16'h0004;
  localparam logic [VEC_W-1:0] REALTIME_IRQ_BASE       = 16'h0014;
  localparam logic [VEC_W-1:0] TWOWIRE_C_IRQ_BASE      = 16'h0018;
  localparam logic [VEC_W-1:0] TIMER_C0_IRQ_BASE       = 16'h001C;
  localparam logic [VEC_W-1:0] TIMER_C1_IRQ_BASE       = 16'h0028;
  localparam logic [VEC_W-1:0] SERIAL_PERIPH_C_VECTOR  = 16'h0030;
  localparam logic [VEC_W-1:0] SERIAL_XCVR_C0_IRQ_BASE = 16'h0032;
  localparam logic [VEC_W-1:0] NONVOLATILE_IRQ_BASE    = 16'h0040;
  localparam logic [VEC_W-1:0] PORT_B_IRQ_BASE         = 16'h0044;
  localparam logic [VEC_W-1:0] PORT_E_IRQ_BASE         = 16'h0056;
  localparam logic [VEC_W-1:0] TWOWIRE_E_IRQ_BASE      = 16'h005A;
  localparam logic [VEC_W-1:0] TIMER_E0_IRQ_BASE       = 16'h005E;
  localparam logic [VEC_W-1:0] PORT_D_IRQ_BASE         = 16'h0080;
  localparam logic [VEC_W-1:0] PORT_A_IRQ_BASE         = 16'h0084;
  localparam logic [VEC_W-1:0] COMPARATOR_A_IRQ_BASE   = 16'h0088;
  localparam logic [VEC_W-1:0] CONVERTER_A_IRQ_BASE    = 16'h008E; // see R17
  localparam logic [VEC_W-1:0] TIMER_D0_IRQ_BASE       = 16'h009A; // see R17
  localparam logic [VEC_W-1:0] SERIAL_PERIPH_D_VECTOR  = 16'h00AE; // see R18
  localparam logic [VEC_W-1:0] SERIAL_XCVR_D0_IRQ_BASE = 16'h00B0;

  // Boot section start, word address (arbitrary default)
  localparam logic [VEC_W-1:0] BOOT_START = 16'h1000;

  // Wake-up halt
  localparam int WAKE_HALT_CYC = 4;
  localparam logic [2:0] WAKE_HALT_CNT = 3'(WAKE_HALT_CYC);

  // Source index to peripheral base (one base per source slot)
  function automatic logic [VEC_W-1:0] src_base(input logic [SRC_W-1:0] s);
    case (s)
      4'h0:    src_base = PORT_C_IRQ_BASE;          // see R10
      4'h1:    src_base = REALTIME_IRQ_BASE;        // see R11
      4'h2:    src_base = TWOWIRE_C_IRQ_BASE;       // see R11
      4'h3:    src_base = TIMER_C0_IRQ_BASE;        // see R12
      4'h4:    src_base = TIMER_C1_IRQ_BASE;        // see R12
      4'h5:    src_base = SERIAL_PERIPH_C_VECTOR;   // see R13
      4'h6:    src_base = SERIAL_XCVR_C0_IRQ_BASE;  // see R13
      4'h7:    src_base = NONVOLATILE_IRQ_BASE;     // see R14
      4'h8:    src_base = PORT_B_IRQ_BASE;          // see R14
      4'h9:    src_base = PORT_E_IRQ_BASE;          // see R15
      4'hA:    src_base = TWOWIRE_E_IRQ_BASE;       // see R15
      4'hB:    src_base = TIMER_E0_IRQ_BASE;        // see R15
      4'hC:    src_base = PORT_D_IRQ_BASE;          // see R16
      4'hD:    src_base = PORT_A_IRQ_BASE;          // see R16
      4'hE:    src_base = COMPARATOR_A_IRQ_BASE;    // see R16
      default: src_base = SERIAL_XCVR_D0_IRQ_BASE;  // see R18
    endcase
  endfunction

  typedef enum logic [1:0] {ST_RUN, ST_HALT} mlic_run_t;

endpackage

// ===== rtl/mlic_arb.sv
// Priority picker for one level: fixed (lowest index) or round robin.
// Assumes request vectors from the same clock domain.
`timescale 1ns/1ps
module mlic_arb (
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic [mlic_pkg::NUM_SRC-1:0] req,
  input  wire logic                        rr_en,
  input  wire logic                        grant_take,
  output logic                             any,
  output logic [mlic_pkg::SRC_W-1:0]       pick
);

  logic [mlic_pkg::SRC_W-1:0] last_ff;
  logic [mlic_pkg::SRC_W-1:0] idx;
  logic                       found;

  // Fixed: lowest index wins; round robin starts after the last winner
  always_comb begin
    found = 1'b0;
    pick  = '0;
    for (int i = 0; i < mlic_pkg::NUM_SRC; i++) begin
      idx = rr_en ? mlic_pkg::SRC_W'(last_ff + 4'h1 + 4'(i)) : 4'(i);
      if (!found && req[idx]) begin
        found = 1'b1;
        pick  = idx;
      end
    end
    any = found;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_ff <= 4'hF;
    end else if (grant_take) begin
      last_ff <= pick;
    end
  end

endmodule // mlic_arb

// ===== rtl/mlic_ctrl.sv
// Multilevel interrupt controller: levels, nesting, vectors, wake halt.
// Assumes request lines are level inputs from logic on sys_clk, held
// until acknowledged; the core pulses irq_ret on each return.
`timescale 1ns/1ps

// Overview of operation
// R01: Three assignable levels, arbitrated by level
// R02: Medium pre-empts a running low routine
// R03: High pre-empts low and medium routines
// R04: Low level fixed or round-robin selectable
// R05: Oscillator fail is non-maskable, vector 0x002
// R06: Each source has its own vector
// R07: Vector is base plus interrupt offset
// R08: Vectors are word addresses
// R09: Option relocates table to boot start
// R10: Reset 0x000, port C base 0x004
// R11: Real-time 0x014, two-wire C 0x018
// R12: Timer C0 0x01C, timer C1 0x028
// R13: Serial periph C 0x030, transceiver C 0x032
// R14: Nonvolatile 0x040, port B 0x044
// R15: Port E 0x056, two-wire 0x05A, timer 0x05E
// R16: Port D 0x080, port A 0x084, comparator 0x088
// R17: Converter A 0x08E, timer D0 0x09A
// R18: Serial periph D 0x0AE, transceiver D 0x0B0
// R19: On wake, higher pending served first
// R20: Core halted four cycles after wake
// R21: Same or lower level waits for return
// R22: Fixed low arbitration: lowest vector wins
module mlic_ctrl (
  input  wire logic                          sys_clk,
  input  wire logic                          reset_n,
  input  wire logic [mlic_pkg::NUM_SRC-1:0]  irq_req,
  input  wire logic [2*mlic_pkg::NUM_SRC-1:0] irq_level,
  input  wire logic [4*mlic_pkg::NUM_SRC-1:0] irq_offset,
  input  wire logic                          osc_fail,
  input  wire logic                          low_en,
  input  wire logic                          med_en,
  input  wire logic                          high_en,
  input  wire logic                          rr_en,
  input  wire logic                          vec_boot,
  input  wire logic                          sleeping,
  input  wire logic                          irq_ack,
  input  wire logic                          irq_ret,
  output logic                               irq_valid,
  output logic [mlic_pkg::VEC_W-1:0]         irq_vector,
  output logic [mlic_pkg::SRC_W-1:0]         irq_src,
  output logic                               irq_nmi,
  output logic [3:0]                         active_levels,
  output logic                               cpu_halt
);

  // ****************************************************************
  // Request sorting by level
  // ****************************************************************
  logic [mlic_pkg::NUM_SRC-1:0] req_low;
  logic [mlic_pkg::NUM_SRC-1:0] req_med;
  logic [mlic_pkg::NUM_SRC-1:0] req_high;

  genvar g;
  generate
    for (g = 0; g < mlic_pkg::NUM_SRC; g++) begin : g_sort
      // Level field per source chooses its arbiter
      assign req_low[g]  = irq_req[g] && low_en &&
                           irq_level[2*g +: 2] == mlic_pkg::LVL_LOW;  // see R01
      assign req_med[g]  = irq_req[g] && med_en &&
                           irq_level[2*g +: 2] == mlic_pkg::LVL_MED;  // see R01
      assign req_high[g] = irq_req[g] && high_en &&
                           irq_level[2*g +: 2] == mlic_pkg::LVL_HIGH; // see R01
    end
  endgenerate

  logic                       any_low;
  logic                       any_med;
  logic                       any_high;
  logic [mlic_pkg::SRC_W-1:0] pick_low;
  logic [mlic_pkg::SRC_W-1:0] pick_med;
  logic [mlic_pkg::SRC_W-1:0] pick_high;
  logic                       take_low;

  // Lower index maps to lower base address, so fixed order = lowest vector
  mlic_arb u_arb_low (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .req        (req_low),
    .rr_en      (rr_en),       // see R04
    .grant_take (take_low),
    .any        (any_low),
    .pick       (pick_low)     // see R22
  );

  mlic_arb u_arb_med (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .req        (req_med),
    .rr_en      (1'b0),
    .grant_take (1'b0),
    .any        (any_med),
    .pick       (pick_med)
  );

  mlic_arb u_arb_high (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .req        (req_high),
    .rr_en      (1'b0),
    .grant_take (1'b0),
    .any        (any_high),
    .pick       (pick_high)
  );

  // ****************************************************************
  // Nesting state: bit 0 low, 1 medium, 2 high, 3 non-maskable
  // ****************************************************************
  logic [3:0] active_ff;
  logic       nmi_pend_ff;
  logic       nmi_seen_ff;

  // Highest level currently being served decides who may pre-empt
  logic can_high;
  logic can_med;
  logic can_low;
  assign can_high = ~|active_ff[3:2];                     // see R03
  assign can_med  = ~|active_ff[3:1];                     // see R02
  assign can_low  = ~|active_ff[3:0];                     // see R21

  logic       nxt_valid;
  logic       nxt_nmi;
  logic [1:0] nxt_lvl;
  logic [mlic_pkg::SRC_W-1:0] nxt_src;

  // Higher levels checked first, so wake-up serves them in order
  always_comb begin
    nxt_valid = 1'b0;
    nxt_nmi   = 1'b0;
    nxt_lvl   = mlic_pkg::LVL_OFF;
    nxt_src   = '0;
    if (nmi_pend_ff && !active_ff[3]) begin                // see R05
      nxt_valid = 1'b1;
      nxt_nmi   = 1'b1;
    end else if (any_high && can_high) begin               // see R19
      nxt_valid = 1'b1;
      nxt_lvl   = mlic_pkg::LVL_HIGH;
      nxt_src   = pick_high;
    end else if (any_med && can_med) begin
      nxt_valid = 1'b1;
      nxt_lvl   = mlic_pkg::LVL_MED;
      nxt_src   = pick_med;
    end else if (any_low && can_low) begin
      nxt_valid = 1'b1;
      nxt_lvl   = mlic_pkg::LVL_LOW;
      nxt_src   = pick_low;
    end
  end

  // ****************************************************************
  // Vector forming
  // ****************************************************************
  function automatic logic [mlic_pkg::VEC_W-1:0] form_vec(
    input logic                       nmi,
    input logic [mlic_pkg::SRC_W-1:0] src,
    input logic [mlic_pkg::OFS_W-1:0] ofs,
    input logic                       boot
  );
    logic [mlic_pkg::VEC_W-1:0] v;
    if (nmi) begin
      v = mlic_pkg::OSCILLATOR_FAIL_VECTOR;                   // see R05
    end else if (mlic_pkg::src_base(src) ==
                 mlic_pkg::SERIAL_PERIPH_C_VECTOR) begin
      // Single vector: an offset would alias the next base
      v = mlic_pkg::SERIAL_PERIPH_C_VECTOR;                   // see R13
    end else begin
      // Word units: the core loads this straight into the PC
      v = mlic_pkg::src_base(src) +
          mlic_pkg::VEC_W'(ofs);                          // see R07, R08
    end
    if (boot) begin
      v = mlic_pkg::VEC_W'(v + mlic_pkg::BOOT_START);      // see R09
    end
    form_vec = v;
  endfunction

  logic [mlic_pkg::OFS_W-1:0] sel_ofs;
  assign sel_ofs = irq_offset[4*nxt_src +: 4];             // see R06

  // ****************************************************************
  // Wake-up halt and run state
  // ****************************************************************
  mlic_pkg::mlic_run_t run_ff;
  logic [2:0]          halt_cnt_ff;
  logic                sleep_d_ff;
  logic                wake;

  assign wake = sleep_d_ff && !sleeping;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_d_ff <= 1'b0;
    end else begin
      sleep_d_ff <= sleeping;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_ff      <= mlic_pkg::ST_RUN;
      halt_cnt_ff <= '0;
    end else begin
      case (run_ff)
        mlic_pkg::ST_RUN: begin
          if (wake) begin
            run_ff      <= mlic_pkg::ST_HALT;
            halt_cnt_ff <= mlic_pkg::WAKE_HALT_CNT;        // see R20
          end
        end
        mlic_pkg::ST_HALT: begin
          halt_cnt_ff <= halt_cnt_ff - 3'h1;
          if (halt_cnt_ff == 3'h1) begin
            run_ff <= mlic_pkg::ST_RUN;
          end
        end
        default: run_ff <= mlic_pkg::ST_RUN;
      endcase
    end
  end

  assign cpu_halt = (run_ff == mlic_pkg::ST_HALT);

  // ****************************************************************
  // Offer and acknowledge
  // ****************************************************************
  logic take;
  // Offer held while halted; vector registered below
  assign irq_valid = nxt_valid && !cpu_halt && !sleeping;
  assign take      = irq_valid && irq_ack;
  assign take_low  = take && !nxt_nmi && nxt_lvl == mlic_pkg::LVL_LOW;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_vector <= mlic_pkg::RESET_VECTOR;                   // see R10
      irq_src    <= '0;
      irq_nmi    <= 1'b0;
    end else begin
      irq_vector <= form_vec(nxt_nmi, nxt_src, sel_ofs, vec_boot);
      irq_src    <= nxt_src;
      irq_nmi    <= nxt_nmi;
    end
  end

  // Oscillator failure edge: set wins over a same-cycle take
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_seen_ff <= 1'b0;
      nmi_pend_ff <= 1'b0;
    end else begin
      nmi_seen_ff <= osc_fail;
      if (osc_fail && !nmi_seen_ff) begin
        nmi_pend_ff <= 1'b1;
      end else if (take && nxt_nmi) begin
        nmi_pend_ff <= 1'b0;
      end
    end
  end

  // Entry sets the level bit; return clears the highest set bit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_ff <= 4'h0;
    end else if (take) begin
      if (nxt_nmi) begin
        active_ff[3] <= 1'b1;
      end else begin
        active_ff[nxt_lvl - 2'h1] <= 1'b1;                  // see R02, R03
      end
    end else if (irq_ret) begin
      if (active_ff[3]) begin
        active_ff[3] <= 1'b0;
      end else if (active_ff[2]) begin
        active_ff[2] <= 1'b0;
      end else if (active_ff[1]) begin
        active_ff[1] <= 1'b0;
      end else begin
        active_ff[0] <= 1'b0;
      end
    end
  end

  assign active_levels = active_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  wake_halt_len_a: assert property ( // see R20
    @(posedge sys_clk) disable iff (!reset_n)
    (wake && run_ff == mlic_pkg::ST_RUN) |=> cpu_halt [*4] ##1 !cpu_halt)
    else $error("halt after wake is not four cycles");

  nmi_vector_a: assert property ( // see R05
    @(posedge sys_clk) disable iff (!reset_n)
    (nxt_nmi && !vec_boot) |=> irq_vector == 16'h0002)
    else $error("non-maskable vector wrong");

  low_blocked_a: assert property ( // see R21
    @(posedge sys_clk) disable iff (!reset_n)
    active_ff[0] |-> !(irq_valid && nxt_lvl == mlic_pkg::LVL_LOW))
    else $error("low offered while low active");

  med_preempt_a: assert property ( // see R02
    @(posedge sys_clk) disable iff (!reset_n)
    (active_ff == 4'h1 && any_med && !any_high && !nmi_pend_ff &&
     !cpu_halt && !sleeping) |-> irq_valid && nxt_lvl == mlic_pkg::LVL_MED)
    else $error("medium did not pre-empt low");

  high_preempt_a: assert property ( // see R03
    @(posedge sys_clk) disable iff (!reset_n)
    (active_ff[3:2] == 2'h0 && any_high && !nmi_pend_ff &&
     !cpu_halt && !sleeping) |-> irq_valid && nxt_lvl == mlic_pkg::LVL_HIGH)
    else $error("high did not pre-empt");

  level_order_a: assert property ( // see R19
    @(posedge sys_clk) disable iff (!reset_n)
    (irq_valid && any_high && can_high && !nmi_pend_ff) |->
      nxt_lvl == mlic_pkg::LVL_HIGH)
    else $error("lower level served before higher");

  nest_entry_a: assert property ( // see R01
    @(posedge sys_clk) disable iff (!reset_n)
    (take && !nxt_nmi && nxt_lvl == mlic_pkg::LVL_MED) |=> active_ff[1])
    else $error("medium entry not recorded");

  nmi_sticky_a: assert property ( // see R05
    @(posedge sys_clk) disable iff (!reset_n)
    (osc_fail && !nmi_seen_ff) |=> nmi_pend_ff)
    else $error("oscillator fail lost");

endmodule // mlic_ctrl

// ===== test/mlic_core_model.sv
// Stand-in for the core and the requesting peripherals of the controller.
// Assumes the controller runs on the same sys_clk and reset_n.
`timescale 1ns/1ps
module mlic_core_model (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        irq_valid,
  input  wire logic [15:0] irq_vector,
  input  wire logic [3:0]  irq_src,
  input  wire logic        irq_nmi,
  input  wire logic        stall,
  input  wire logic        do_ret,
  input  wire logic [15:0] raise,
  output logic             irq_ack,
  output logic             irq_ret,
  output logic [15:0]      irq_req,
  output logic [15:0]      taken_vec,
  output logic [3:0]       taken_src,
  output logic             taken_nmi,
  output int               take_cnt
);
  logic take;
  logic seen_ff;

  assign take = irq_valid & irq_ack;

  // ****************************************
  // Core side
  // ****************************************
  // Ack only once the offer has stood a cycle, so the vector has settled
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ack <= 1'b0;
      seen_ff <= 1'b0;
      irq_ret <= 1'b0;
    end else begin
      seen_ff <= irq_valid & ~take;
      irq_ret <= do_ret;
      if (take || !irq_valid) irq_ack <= 1'b0;
      else if (seen_ff && !stall) irq_ack <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      taken_vec <= 16'h0000;
      taken_src <= 4'h0;
      taken_nmi <= 1'b0;
      take_cnt  <= 0;
    end else if (take) begin
      taken_vec <= irq_vector;
      taken_src <= irq_src;
      taken_nmi <= irq_nmi;
      take_cnt  <= take_cnt + 1;
    end
  end

  // ****************************************
  // Peripheral side
  // ****************************************
  // A request stays up until its own offer is taken
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_req <= 16'h0000;
    end else begin
      irq_req <= (irq_req | raise)
               & ~((take && !irq_nmi) ? (16'h0001 << irq_src) : 16'h0000);
    end
  end
endmodule // mlic_core_model

// ===== test/mlic_ctrl_tb.sv
// Self-checking bench of the multilevel interrupt controller.
// Assumes mlic_pkg, mlic_ctrl and mlic_core_model are compiled first.
`timescale 1ns/1ps
module mlic_ctrl_tb;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [31:0] irq_level = 32'h0000_0000;
  logic [63:0] irq_offset = 64'h0;
  logic        osc_fail = 1'b0, low_en = 1'b1, med_en = 1'b1;
  logic        high_en = 1'b1, rr_en = 1'b0, vec_boot = 1'b0;
  logic        sleeping = 1'b0, stall = 1'b0, do_ret = 1'b0;
  logic [15:0] raise = 16'h0000;
  logic [15:0] irq_req, irq_vector, taken_vec;
  logic        irq_ack, irq_ret, irq_valid, irq_nmi, cpu_halt, taken_nmi;
  logic [3:0]  irq_src, active_levels, taken_src;
  int          take_cnt, seed, error_cnt = 0, checks_done = 0;
  int          takes_seen = 0;

  always #25 sys_clk = ~sys_clk;

  mlic_ctrl mlic_ctrl_i (.sys_clk, .reset_n, .irq_req, .irq_level,
    .irq_offset, .osc_fail, .low_en, .med_en, .high_en, .rr_en, .vec_boot,
    .sleeping, .irq_ack, .irq_ret, .irq_valid, .irq_vector, .irq_src,
    .irq_nmi, .active_levels, .cpu_halt);

  mlic_core_model mlic_core_model_i (.sys_clk, .reset_n, .irq_valid,
    .irq_vector, .irq_src, .irq_nmi, .stall, .do_ret, .raise, .irq_ack,
    .irq_ret, .irq_req, .taken_vec, .taken_src, .taken_nmi, .take_cnt);

  // ****************************************
  // Expectations and checks
  // ****************************************
  function automatic logic [15:0] exp_base(input logic [3:0] s);
    case (s)
      4'h0:    exp_base = 16'h0004;
      4'h1:    exp_base = 16'h0014;
      4'h2:    exp_base = 16'h0018;
      4'h3:    exp_base = 16'h001C;
      4'h4:    exp_base = 16'h0028;
      4'h5:    exp_base = 16'h0030;
      4'h6:    exp_base = 16'h0032;
      4'h7:    exp_base = 16'h0040;
      4'h8:    exp_base = 16'h0044;
      4'h9:    exp_base = 16'h0056;
      4'hA:    exp_base = 16'h005A;
      4'hB:    exp_base = 16'h005E;
      4'hC:    exp_base = 16'h0080;
      4'hD:    exp_base = 16'h0084;
      4'hE:    exp_base = 16'h0088;
      default: exp_base = 16'h00B0;
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Counts takes globally, so a take that lands early is not missed
  task automatic wait_take();
    for (int i = 0; i < 400; i++) begin
      @(negedge sys_clk);
      if (take_cnt > takes_seen) begin
        takes_seen++;
        return;
      end
    end
    error_cnt++;
    $display("wrong value at %0t: no interrupt taken", $time);
    report_and_stop();
  endtask

  task automatic serve(input logic [3:0] s, input logic [3:0] act);
    wait_take();
    check(16'(taken_src), 16'(s));
    check(16'(active_levels), 16'(act));
  endtask

  task automatic ret();
    @(posedge sys_clk);
    do_ret <= 1'b1;
    @(posedge sys_clk);
    do_ret <= 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic raise_irq(input logic [15:0] m);
    @(posedge sys_clk);
    raise <= m;
    @(posedge sys_clk);
    raise <= 16'h0000;
  endtask

  task automatic set_levels(input logic [31:0] v);
    @(posedge sys_clk);
    irq_level <= v;
  endtask

  task automatic quiet(input int n);
    repeat (n) @(negedge sys_clk);
    check(16'(irq_valid), 16'h0000);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int n;
    seed = 32'hA9DC3577;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check(irq_vector, 16'h0000);
    check(16'({irq_valid, cpu_halt, active_levels}), 16'h0000);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    irq_offset <= {$random(seed), $random(seed)};
    set_levels({16{mlic_pkg::LVL_MED}});
    // Every slot, random offset and table placement, slow core on odd slots
    for (int s = 0; s < 16; s++) begin
      @(posedge sys_clk);
      vec_boot <= 1'($random(seed));
      stall <= s[0];
      raise_irq(16'h0001 << s);
      repeat (4) @(posedge sys_clk);
      stall <= 1'b0;
      wait_take();
      check(taken_vec, exp_base(4'(s))
            + (s == 5 ? 16'h0000 : 16'(irq_offset[4*s+:4]))
            + (vec_boot ? mlic_pkg::BOOT_START : 16'h0000));
      check(16'(taken_src), 16'(s));
      ret();
    end
    set_levels({16{mlic_pkg::LVL_LOW}});
    for (int m = 0; m < 2; m++) begin
      @(posedge sys_clk);
      rr_en <= m[0];
      vec_boot <= 1'b0;
      raise_irq(16'h0020);
      serve(4'h5, 4'h1);
      ret();
      raise_irq(16'h0204);
      serve(m[0] ? 4'h9 : 4'h2, 4'h1);
      ret();
      serve(m[0] ? 4'h2 : 4'h9, 4'h1);
      ret();
    end
    // Nesting: low, then medium, then high, with a low held back
    set_levels(32'h0000_01E4);
    raise_irq(16'h0002);
    serve(4'h1, 4'h1);
    raise_irq(16'h0010);
    quiet(8);
    raise_irq(16'h0004);
    serve(4'h2, 4'h3);
    raise_irq(16'h0008);
    serve(4'h3, 4'h7);
    ret();
    check(16'(active_levels), 16'h0003);
    ret();
    ret();
    serve(4'h4, 4'h1);
    ret();
    // Wake with a low and a high pending
    set_levels(32'h0000_C001);
    @(posedge sys_clk);
    sleeping <= 1'b1;
    raise_irq(16'h0081);
    quiet(5);
    @(posedge sys_clk);
    sleeping <= 1'b0;
    n = 0;
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk);
      if (cpu_halt === 1'b1) begin
        n++;
        check(16'(irq_valid), 16'h0000);
      end
    end
    check(16'(n), 16'h0004);
    serve(4'h7, 4'h4);
    ret();
    serve(4'h0, 4'h1);
    ret();
    // Oscillator failure with every level masked
    @(posedge sys_clk);
    low_en <= 1'b0;
    med_en <= 1'b0;
    high_en <= 1'b0;
    raise_irq(16'h0001);
    quiet(6);
    @(posedge sys_clk);
    osc_fail <= 1'b1;
    wait_take();
    check(taken_vec, 16'h0002);
    check(16'({taken_nmi, active_levels}), 16'h0018);
    @(posedge sys_clk);
    osc_fail <= 1'b0;
    ret();
    @(posedge sys_clk);
    low_en <= 1'b1;
    serve(4'h0, 4'h1);
    ret();
    report_and_stop();
  end
endmodule // mlic_ctrl_tb
